/* File: hdl/dvt_top.sv */
// dvt_top: video-mode timing and packet scheduling of the serial display host
`default_nettype none
`timescale 1ns/100ps

// Functional notes
// [RULE1] high-speed traffic uses the lane count held in the PHY config register.
// [RULE2] every video-path packet carries the configured virtual channel.
// [RULE3] pixel depth and variant follow the three-bit color coding field.
// [RULE4] software keeps 18 bpp packed line lengths a multiple of four.
// [RULE5] each parallel input control signal has its own active-low bit.
// [RULE6] 18 bpp uses loose packing when the loose bit is set.
// [RULE7] low power only in enabled periods with enough remaining time; code also requests it when idle and after burst line packets.
// [RULE8] with frame ack set, request a turnaround acknowledge at frame end.
// [RULE9] burst sends one uninterrupted packet per line, then low power.
// [RULE10] burst ignores chunk count and null packet size.
// [RULE11] non-burst splits a line into packets, buffering one packet.
// [RULE12] mode type: 00 sync pulses, 01 sync events, upper bit set burst.
// [RULE13] each video packet holds the programmed packet size in pixels.
// [RULE14] multi-packet enable divides active video into chunk count packets.
// [RULE15] null packets only with both null and multi-packet enables.
// [RULE16] null packets carry the programmed null size.
// [RULE17] the line period is counted in lane byte clock cycles.
// [RULE18] sync active and back porch counted in lane byte clock cycles.
// [RULE19] vertical sync, back porch and front porch line counts.
// [RULE20] the frame sends the programmed number of active lines.
// [RULE21] frame: sync, back porch, active, front porch; lines likewise.
module dvt_top import dvt_pkg::*; (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST_N,
  input  wire logic        I_CE,
  input  wire logic        I_LANE_BYTE_CLK,
  input  wire logic        I_DPI_DE,
  input  wire logic        I_DPI_VSYNC,
  input  wire logic        I_DPI_HSYNC,
  input  wire logic        I_DPI_SHUTDN,
  input  wire logic        I_DPI_COLORM,
  input  wire logic        I_CFG_WE,
  input  wire logic [2:0]  I_CFG_SEL,
  input  wire logic [31:0] I_CFG_WDATA,
  output logic      [31:0] O_CFG_RDATA,
  output var dvt_pkt_t     O_PKT,
  output logic      [1:0]  O_LANES,
  output logic             O_LP_REQ,
  output logic             O_BTA_REQ,
  output logic             O_COLOR_MODE,
  output logic      [4:0]  O_VPHASE
);

  // *****************************************************
  // system clock domain: reset release and input pins
  // *****************************************************
  logic        rst_meta_q;
  logic        rst_q;
  logic [4:0]  pin_s;
  logic [4:0]  lvl_q;
  logic [31:0] cfg_q [CFG_NUM];
  logic        cfg_tgl_q;
  logic        frm_tgl_q;
  logic        pix_tgl_q;
  logic [10:0] pix_cnt_q;
  logic        vs_prev_q;
  logic        hs_prev_q;
  logic [31:0] rd_q;

  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  dvt_sync #(.W(5)) u_pin_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst_n (rst_q),
    .i_d     ({I_DPI_COLORM, I_DPI_SHUTDN, I_DPI_HSYNC,
               I_DPI_VSYNC, I_DPI_DE}),
    .o_q     (pin_s)
  );

  wire dvt_dpi_cfg_t  s_dpi  = dvt_dpi_cfg_t'(cfg_q[SEL_DPI]);
  wire dvt_pkt_cfg_t  s_pktc = dvt_pkt_cfg_t'(cfg_q[SEL_PKT]);
  wire logic [4:0]    pin_pol = {s_dpi.colorm_low, s_dpi.shutdn_low,
                                 s_dpi.hsync_low, s_dpi.vsync_low,
                                 s_dpi.de_low};
  wire logic [4:0]    pin_lv  = pin_s ^ pin_pol; // [RULE5]
  wire logic          de_on   = lvl_q[0];
  wire logic          vs_rise = lvl_q[1] && !vs_prev_q;
  wire logic          hs_rise = lvl_q[2] && !hs_prev_q;
  // one packet's worth of pixels has arrived
  wire logic          pix_full = de_on
                                 && (11'(pix_cnt_q + 11'h1) == s_pktc.pkt_size);
  wire logic          cfg_hit  = I_CFG_WE && (I_CFG_SEL < 3'(CFG_NUM));
  wire logic [31:0]   rd_d     = (I_CFG_SEL < 3'(CFG_NUM)) ? cfg_q[I_CFG_SEL] :
                                 (I_CFG_SEL == SEL_STAT) ?
                                 {21'h0, pix_cnt_q} : 32'h0;

  // *****************************************************
  // configuration registers
  // *****************************************************
  generate
    for (genvar gi = 0; gi < CFG_NUM; gi++)
    begin : g_cfg
      always_ff @(posedge I_CLK_SYS or negedge rst_q)
      begin
        if (!rst_q)
          cfg_q[gi] <= CFG_RST;
        else if (I_CE && cfg_hit && (I_CFG_SEL == 3'(gi)))
          cfg_q[gi] <= I_CFG_WDATA;
      end
    end
  endgenerate

  // *****************************************************
  // pixel accounting and event toggles
  // *****************************************************
  // pixels are counted, not stored: the link side spends one credit per
  // packet, which stands in for the pixel store a full line would need
  always_ff @(posedge I_CLK_SYS or negedge rst_q)
  begin
    if (!rst_q)
    begin
      lvl_q     <= 5'h0;
      cfg_tgl_q <= 1'b0;
      frm_tgl_q <= 1'b0;
      pix_tgl_q <= 1'b0;
      pix_cnt_q <= 11'h0;
      vs_prev_q <= 1'b0;
      hs_prev_q <= 1'b0;
      rd_q      <= 32'h0;
    end
    else if (I_CE)
    begin
      lvl_q     <= pin_lv;
      vs_prev_q <= lvl_q[1];
      hs_prev_q <= lvl_q[2];
      rd_q      <= rd_d;
      if (cfg_hit)
        cfg_tgl_q <= !cfg_tgl_q;
      if (vs_rise)
        frm_tgl_q <= !frm_tgl_q;
      if (hs_rise || vs_rise)
        pix_cnt_q <= 11'h0;
      else if (pix_full)
      begin
        pix_cnt_q <= 11'h0;
        pix_tgl_q <= !pix_tgl_q; // [RULE11] [RULE9]
      end
      else if (de_on)
        pix_cnt_q <= 11'(pix_cnt_q + 11'h1);
    end
  end

  assign O_CFG_RDATA = rd_q;

  // *****************************************************
  // link domain: reset release and crossings
  // *****************************************************
  logic          lrst_meta_q;
  logic          lrst_q;
  logic [5:0]    lk_s;
  logic [2:0]    lk_prev_q;
  dvt_phy_cfg_t  phy_q;
  dvt_dpi_cfg_t  dpi_q;
  dvt_mode_cfg_t mode_q;
  dvt_pkt_cfg_t  pktc_q;
  dvt_line_cfg_t line_q;
  dvt_vt_cfg_t   vt_q;

  always_ff @(posedge I_LANE_BYTE_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      lrst_meta_q <= 1'b0;
      lrst_q      <= 1'b0;
    end
    else
    begin
      lrst_meta_q <= 1'b1;
      lrst_q      <= lrst_meta_q;
    end
  end

  dvt_sync #(.W(6)) u_lk_sync (
    .i_clk   (I_LANE_BYTE_CLK),
    .i_rst_n (lrst_q),
    .i_d     ({I_CE, lvl_q[4], lvl_q[3], pix_tgl_q, frm_tgl_q, cfg_tgl_q}),
    .o_q     (lk_s)
  );

  wire logic lce     = lk_s[5];
  wire logic shut    = lk_s[3];
  wire logic cfg_evt = lk_s[0] ^ lk_prev_q[0];
  wire logic frm_evt = lk_s[1] ^ lk_prev_q[1];
  wire logic pix_evt = lk_s[2] ^ lk_prev_q[2];

  // config words were stable for two link edges before the toggle shows
  always_ff @(posedge I_LANE_BYTE_CLK or negedge lrst_q)
  begin
    if (!lrst_q)
    begin
      lk_prev_q <= 3'h0;
      phy_q     <= dvt_phy_cfg_t'(CFG_RST);
      dpi_q     <= dvt_dpi_cfg_t'(CFG_RST);
      mode_q    <= dvt_mode_cfg_t'(CFG_RST);
      pktc_q    <= dvt_pkt_cfg_t'(CFG_RST);
      line_q    <= dvt_line_cfg_t'(CFG_RST);
      vt_q      <= dvt_vt_cfg_t'(CFG_RST);
    end
    else if (lce)
    begin
      lk_prev_q <= lk_s[2:0];
      if (cfg_evt)
      begin
        phy_q  <= dvt_phy_cfg_t'(cfg_q[SEL_PHY]);
        dpi_q  <= dvt_dpi_cfg_t'(cfg_q[SEL_DPI]);
        mode_q <= dvt_mode_cfg_t'(cfg_q[SEL_MODE]);
        pktc_q <= dvt_pkt_cfg_t'(cfg_q[SEL_PKT]);
        line_q <= dvt_line_cfg_t'(cfg_q[SEL_LINE]);
        vt_q   <= dvt_vt_cfg_t'(cfg_q[SEL_VT]);
      end
    end
  end

  // *****************************************************
  // link domain: mode decode
  // *****************************************************
  dvt_vst_t    vst_q;
  logic [10:0] lcnt_q;
  logic [13:0] hcnt_q;
  logic [15:0] busy_q;
  logic [9:0]  chunk_q;
  logic        null_pend_q;
  logic [3:0]  credit_q;
  dvt_pkt_t    pkt_q;
  logic        lp_q;
  logic        bta_q;
  logic [5:0]  dt_vid;
  logic [15:0] wc_vid;

  wire logic       burst   = mode_q.mode_type[1]; // [RULE12]
  wire logic       pulse   = !burst && !mode_q.mode_type[0]; // [RULE12]
  wire logic       multi   = mode_q.en_multi && !burst; // [RULE10]
  wire logic [9:0] chunks  = (multi && (pktc_q.num_chunks != 10'h0)) ?
                             pktc_q.num_chunks : 10'h1; // [RULE14]
  wire logic       null_on = mode_q.en_null && multi; // [RULE15]
  wire logic [1:0] lsh     = (phy_q.n_lanes == 2'h0) ? 2'h0 :
                             (phy_q.n_lanes == 2'h1) ? 2'h1 : 2'h2;

  dvt_fmt u_fmt (
    .i_coding (dpi_q.coding),
    .i_loose  (dpi_q.loose18),
    .i_npix   (pktc_q.pkt_size), // [RULE13]
    .o_dt     (dt_vid),
    .o_wc     (wc_vid)
  );

  // *****************************************************
  // link domain: frame and line position
  // *****************************************************
  // phases with a zero line count are skipped
  function automatic dvt_vst_t nxt_phase(input dvt_vst_t s,
                                         input dvt_vt_cfg_t v);
    dvt_vst_t n;
    n = V_IDLE;
    case (s)
      V_IDLE:  n = (v.vsa != 4'h0) ? V_SA :
                   (v.vbp != 6'h0) ? V_BP :
                   (v.vact != 11'h0) ? V_ACT :
                   (v.vfp != 6'h0) ? V_FP : V_IDLE;
      V_SA:    n = (v.vbp != 6'h0) ? V_BP :
                   (v.vact != 11'h0) ? V_ACT :
                   (v.vfp != 6'h0) ? V_FP : V_IDLE;
      V_BP:    n = (v.vact != 11'h0) ? V_ACT :
                   (v.vfp != 6'h0) ? V_FP : V_IDLE;
      V_ACT:   n = (v.vfp != 6'h0) ? V_FP : V_IDLE;
      default: n = V_IDLE;
    endcase
    return n;
  endfunction

  wire dvt_vst_t    nxt_v = nxt_phase(vst_q, vt_q); // [RULE21]
  wire logic [10:0] lim   = (vst_q == V_SA)  ? {7'h0, vt_q.vsa} :
                            (vst_q == V_BP)  ? {5'h0, vt_q.vbp} :
                            (vst_q == V_ACT) ? vt_q.vact :
                            (vst_q == V_FP)  ? {5'h0, vt_q.vfp} : 11'h0; // [RULE19] [RULE20]
  wire logic        run      = (vst_q != V_IDLE) && !shut;
  wire logic        line_end = hcnt_q == 14'(line_q.hline - 14'h1); // [RULE17]
  wire logic        last_ln  = lcnt_q == 11'(lim - 11'h1);
  wire logic        frm_end  = run && line_end && last_ln && (nxt_v == V_IDLE);
  wire logic [13:0] hsa14    = {5'h0, line_q.hsa};
  wire logic [13:0] hstart   = 14'(hsa14 + {5'h0, line_q.hbp}); // [RULE18]
  wire logic        in_sa    = hcnt_q < hsa14;
  wire logic        in_bp    = !in_sa && (hcnt_q < hstart);
  wire logic        in_act   = run && (vst_q == V_ACT) && !in_sa && !in_bp;
  wire logic [13:0] remain   = 14'(line_q.hline - hcnt_q - 14'h1);

  // *****************************************************
  // link domain: packet selection
  // *****************************************************
  wire logic ev_ss  = run && (hcnt_q == 14'h0);
  wire logic ev_se  = run && pulse && (hcnt_q == hsa14) && !ev_ss; // [RULE12]
  wire logic ev_vid = in_act && (busy_q == 16'h0) && (chunk_q != 10'h0)
                      && !null_pend_q && (credit_q != 4'h0); // [RULE9] [RULE11]
  wire logic ev_nul = in_act && (busy_q == 16'h0) && null_pend_q; // [RULE15]
  wire logic vs_first = (vst_q == V_SA) && (lcnt_q == 11'h0);
  wire logic vs_last  = (vst_q == V_SA) && last_ln;
  wire logic act_done = (chunk_q == 10'h0) && !null_pend_q;

  wire logic [5:0]  sel_dt = ev_ss ? (vs_first ? DT_VSS : DT_HSS) :
                             ev_se ? (vs_last ? DT_VSE : DT_HSE) :
                             ev_vid ? dt_vid : DT_NULL; // [RULE21]
  wire logic [15:0] sel_wc = ev_vid ? wc_vid :
                             ev_nul ? {6'h0, pktc_q.null_size} : 16'h0; // [RULE16]
  wire logic        ev_any = ev_ss || ev_se || ev_vid || ev_nul;
  // long packets occupy the link roughly payload over lane count; three
  // lanes are paced as four, which gives a shorter hold than the link needs
  wire logic [15:0] hold = (ev_vid || ev_nul) ?
                           16'(16'(sel_wc + LONG_OVH) >> lsh) : SHORT_CYC; // [RULE1]

  // *****************************************************
  // link domain: low-power permission
  // *****************************************************
  wire logic lp_sel = (vst_q == V_SA)  ? mode_q.lp_en[LP_VSA] :
                      (vst_q == V_BP)  ? mode_q.lp_en[LP_VBP] :
                      (vst_q == V_FP)  ? mode_q.lp_en[LP_VFP] :
                      in_bp            ? mode_q.lp_en[LP_HBP] :
                      (in_act && act_done) ?
                        (mode_q.lp_en[LP_HFP] || burst) :
                      in_act ? mode_q.lp_en[LP_VACT] : 1'b0; // [RULE7] [RULE9]
  wire logic lp_d   = !run || (lp_sel && !ev_any && (busy_q == 16'h0)
                      && (remain > LP_MIN_CYC) && (hcnt_q != 14'h0)); // [RULE7]

  // *****************************************************
  // link domain: timing state
  // *****************************************************
  always_ff @(posedge I_LANE_BYTE_CLK or negedge lrst_q)
  begin
    if (!lrst_q)
    begin
      vst_q  <= V_IDLE;
      lcnt_q <= 11'h0;
      hcnt_q <= 14'h0;
    end
    else if (lce)
    begin
      if (shut)
        vst_q <= V_IDLE;
      else if (vst_q == V_IDLE)
      begin
        hcnt_q <= 14'h0;
        lcnt_q <= 11'h0;
        if (frm_evt)
          vst_q <= nxt_v; // [RULE21]
      end
      else if (line_end)
      begin
        hcnt_q <= 14'h0; // [RULE17]
        if (last_ln)
        begin
          lcnt_q <= 11'h0;
          vst_q  <= nxt_v; // [RULE19] [RULE20]
        end
        else
          lcnt_q <= 11'(lcnt_q + 11'h1);
      end
      else
        hcnt_q <= 14'(hcnt_q + 14'h1);
    end
  end

  // *****************************************************
  // link domain: chunks, credits and pacing
  // *****************************************************
  always_ff @(posedge I_LANE_BYTE_CLK or negedge lrst_q)
  begin
    if (!lrst_q)
    begin
      busy_q      <= 16'h0;
      chunk_q     <= 10'h0;
      null_pend_q <= 1'b0;
      credit_q    <= 4'h0;
    end
    else if (lce)
    begin
      if (ev_any)
        busy_q <= hold;
      else if (busy_q != 16'h0)
        busy_q <= 16'(busy_q - 16'h1);
      if (ev_ss)
        chunk_q <= (vst_q == V_ACT) ? chunks : 10'h0; // [RULE14] [RULE10]
      else if (ev_vid)
        chunk_q <= 10'(chunk_q - 10'h1);
      if (ev_ss || ev_nul)
        null_pend_q <= 1'b0;
      else if (ev_vid)
        null_pend_q <= null_on && (chunk_q != 10'h1); // [RULE15]
      // a new frame discards credits left from an aborted one
      if (frm_evt && (vst_q == V_IDLE))
        credit_q <= 4'h0;
      else if (pix_evt && !ev_vid && (credit_q != 4'hf))
        credit_q <= 4'(credit_q + 4'h1);
      else if (ev_vid && !pix_evt)
        credit_q <= 4'(credit_q - 4'h1);
    end
  end

  // *****************************************************
  // link domain: outputs
  // *****************************************************
  always_ff @(posedge I_LANE_BYTE_CLK or negedge lrst_q)
  begin
    if (!lrst_q)
    begin
      pkt_q <= '0;
      lp_q  <= 1'b1;
      bta_q <= 1'b0;
    end
    else if (lce)
    begin
      pkt_q.valid <= ev_any;
      pkt_q.dt    <= sel_dt;
      pkt_q.vc    <= dpi_q.vc; // [RULE2]
      pkt_q.wc    <= sel_wc; // [RULE13]
      lp_q        <= lp_d;
      bta_q       <= frm_end && mode_q.frame_end_ack_request; // [RULE8]
    end
  end

  assign O_PKT        = pkt_q;
  assign O_LANES      = phy_q.n_lanes; // [RULE1]
  assign O_LP_REQ     = lp_q;
  assign O_BTA_REQ    = bta_q;
  assign O_COLOR_MODE = lk_s[4];
  assign O_VPHASE     = vst_q;

endmodule
`default_nettype wire

/* File: pkg/dvt_pkg.sv */
// dvt_pkg: shared constants, register layouts and types of the video timing block
`default_nettype none
package dvt_pkg;

  // *****************************************************
  // register selection on the configuration port
  // *****************************************************
  localparam int        CFG_NUM  = 6;
  localparam logic [2:0] SEL_PHY  = 3'h0;
  localparam logic [2:0] SEL_DPI  = 3'h1;
  localparam logic [2:0] SEL_MODE = 3'h2;
  localparam logic [2:0] SEL_PKT  = 3'h3;
  localparam logic [2:0] SEL_LINE = 3'h4;
  localparam logic [2:0] SEL_VT   = 3'h5;
  localparam logic [2:0] SEL_STAT = 3'h6;
  localparam logic [31:0] CFG_RST = 32'h0;

  // *****************************************************
  // color coding values and packet data types
  // *****************************************************
  localparam logic [2:0] CC_16_1 = 3'h0;
  localparam logic [2:0] CC_16_2 = 3'h1;
  localparam logic [2:0] CC_16_3 = 3'h2;
  localparam logic [2:0] CC_18_1 = 3'h3;
  localparam logic [2:0] CC_18_2 = 3'h4;
  localparam logic [5:0] DT_VSS     = 6'h01;
  localparam logic [5:0] DT_VSE     = 6'h11;
  localparam logic [5:0] DT_HSS     = 6'h21;
  localparam logic [5:0] DT_HSE     = 6'h31;
  localparam logic [5:0] DT_NULL    = 6'h09;
  localparam logic [5:0] DT_RGB565  = 6'h0e;
  localparam logic [5:0] DT_RGB666  = 6'h1e;
  localparam logic [5:0] DT_RGB666L = 6'h2e;
  localparam logic [5:0] DT_RGB888  = 6'h3e;

  // *****************************************************
  // low-power period bits and link timing
  // *****************************************************
  localparam int LP_VSA  = 0;
  localparam int LP_VBP  = 1;
  localparam int LP_VACT = 2;
  localparam int LP_VFP  = 3;
  localparam int LP_HBP  = 4;
  localparam int LP_HFP  = 5;
  localparam logic [13:0] LP_MIN_CYC = 14'h20;
  localparam logic [15:0] SHORT_CYC  = 16'h4;
  localparam logic [15:0] LONG_OVH   = 16'h6;

  // *****************************************************
  // register layouts
  // *****************************************************
  typedef struct packed {
    logic [29:0] rsvd;
    logic [1:0]  n_lanes;
  } dvt_phy_cfg_t;

  typedef struct packed {
    logic [20:0] rsvd;
    logic        loose18;
    logic        colorm_low;
    logic        shutdn_low;
    logic        hsync_low;
    logic        vsync_low;
    logic        de_low;
    logic [2:0]  coding;
    logic [1:0]  vc;
  } dvt_dpi_cfg_t;

  typedef struct packed {
    logic [19:0] rsvd;
    logic        frame_end_ack_request;
    logic        en_null;
    logic        en_multi;
    logic [5:0]  lp_en;
    logic [1:0]  mode_type;
    logic        rsvd0;
  } dvt_mode_cfg_t;

  typedef struct packed {
    logic        rsvd;
    logic [9:0]  null_size;
    logic [9:0]  num_chunks;
    logic [10:0] pkt_size;
  } dvt_pkt_cfg_t;

  typedef struct packed {
    logic [13:0] hline;
    logic [8:0]  hbp;
    logic [8:0]  hsa;
  } dvt_line_cfg_t;

  typedef struct packed {
    logic [4:0]  rsvd;
    logic [10:0] vact;
    logic [5:0]  vfp;
    logic [5:0]  vbp;
    logic [3:0]  vsa;
  } dvt_vt_cfg_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  dt;
    logic [1:0]  vc;
    logic [15:0] wc;
  } dvt_pkt_t;

  typedef enum logic [4:0] {
    V_IDLE = 5'b00001,
    V_SA   = 5'b00010,
    V_BP   = 5'b00100,
    V_ACT  = 5'b01000,
    V_FP   = 5'b10000
  } dvt_vst_t;

endpackage
`default_nettype wire

/* File: hdl/dvt_sync.sv */
// dvt_sync: two-flop synchroniser for a vector of independent levels
`default_nettype none
`timescale 1ns/100ps
module dvt_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  // meta_q feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      o_q    <= '0;
    end
    else
    begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* File: hdl/dvt_fmt.sv */
// dvt_fmt: color coding decode into data type and payload byte count
`default_nettype none
`timescale 1ns/100ps
module dvt_fmt import dvt_pkg::*; (
  input  wire logic [2:0]  i_coding,
  input  wire logic        i_loose,
  input  wire logic [10:0] i_npix,
  output logic      [5:0]  o_dt,
  output logic      [15:0] o_wc
);
  wire logic [15:0] n16  = {5'h0, i_npix};
  wire logic        is16 = (i_coding == CC_16_1) || (i_coding == CC_16_2)
                           || (i_coding == CC_16_3);
  wire logic        is18 = (i_coding == CC_18_1) || (i_coding == CC_18_2);
  // packed 18 bpp: 9 bytes per 4 pixels, so the count must be a multiple of 4
  wire logic [15:0] wc18 = 16'((n16 + (n16 << 3)) >> 2);
  wire logic [15:0] wc24 = 16'(n16 + (n16 << 1));

  assign o_dt = is16 ? DT_RGB565 :
                is18 ? (i_loose ? DT_RGB666L : DT_RGB666) : DT_RGB888; // [RULE3] [RULE6]
  assign o_wc = is16 ? 16'(n16 << 1) :
                (is18 && !i_loose) ? wc18 : wc24; // [RULE6]
endmodule
`default_nettype wire

/* File: sim/dvt_top_sva.sv */
// dvt_top_sva: port checks of the video timing block
`default_nettype none
`timescale 1ns/100ps
module dvt_top_sva import dvt_pkg::*; (
  input wire logic        I_CLK_SYS,
  input wire logic        I_RST_N,
  input wire logic        I_CE,
  input wire logic        I_LANE_BYTE_CLK,
  input wire logic        I_CFG_WE,
  input wire logic [2:0]  I_CFG_SEL,
  input wire logic [31:0] I_CFG_WDATA,
  input wire dvt_pkt_t    O_PKT,
  input wire logic [1:0]  O_LANES,
  input wire logic        O_LP_REQ,
  input wire logic        O_BTA_REQ,
  input wire logic [4:0]  O_VPHASE
);
  // shadow of the first four words; valid only while config is static
  logic [31:0]   cfg_q [4];
  dvt_mode_cfg_t m;
  dvt_pkt_cfg_t  p;
  assign m = dvt_mode_cfg_t'(cfg_q[2]);
  assign p = dvt_pkt_cfg_t'(cfg_q[3]);
  always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
    if (!I_RST_N)
      cfg_q <= '{default: '0};
    else if (I_CFG_WE && I_CE && I_CFG_SEL < 3'h4)
      cfg_q[I_CFG_SEL[1:0]] <= I_CFG_WDATA;
  // ******
  // link side
  // ******
  default clocking @(posedge I_LANE_BYTE_CLK); endclocking
  default disable iff (!I_RST_N);
  pkt_gap_a: assert property (
    O_PKT.valid && O_PKT.wc != 16'h0 |=> !O_PKT.valid [*3])
    else $error("packets too close");
  vc_tag_a: assert property (
    O_PKT.valid |-> O_PKT.vc == cfg_q[1][1:0]) else $error("bad channel");
  lane_cnt_a: assert property (
    O_PKT.valid |-> O_LANES == cfg_q[0][1:0]) else $error("bad lanes");
  phase_seq_a: assert property ($changed(O_VPHASE) |->
    O_VPHASE > $past(O_VPHASE) || O_VPHASE == 5'h01)
    else $error("phase out of order");
  bta_ack_a: assert property (
    O_BTA_REQ |-> m.frame_end_ack_request ##1 !O_BTA_REQ)
    else $error("bad ack request");
  null_gate_a: assert property (
    O_PKT.valid && O_PKT.dt == DT_NULL |->
    m.en_null && m.en_multi && !m.mode_type[1]) else $error("stray null");
  null_size_a: assert property (
    O_PKT.valid && O_PKT.dt == DT_NULL |-> O_PKT.wc == {6'h0, p.null_size})
    else $error("bad null size");
  vid_size_a: assert property (
    O_PKT.valid && O_PKT.dt == DT_RGB888 |->
    O_PKT.wc == {5'h0, p.pkt_size} * 16'h3) else $error("bad video size");
  vid18_size_a: assert property (
    O_PKT.valid && O_PKT.dt == DT_RGB666 |->
    O_PKT.wc == 16'(({5'h0, p.pkt_size} * 16'h9) >> 2))
    else $error("bad packed size");
  lp_quiet_a: assert property (
    O_PKT.valid |-> !O_LP_REQ) else $error("low power during packet");
  cover property (O_BTA_REQ);
  cover property (O_PKT.valid && O_PKT.dt == DT_NULL);
  cover property ($rose(O_VPHASE[3]));
endmodule
bind dvt_top dvt_top_sva dvt_top_sva_inst (.I_CLK_SYS, .I_RST_N, .I_CE,
  .I_LANE_BYTE_CLK, .I_CFG_WE, .I_CFG_SEL, .I_CFG_WDATA, .O_PKT, .O_LANES,
  .O_LP_REQ, .O_BTA_REQ, .O_VPHASE);
`default_nettype wire

/* File: sim/dvt_sink.sv */
// dvt_sink: display-side model that tallies received packets
`default_nettype none
`timescale 1ns/100ps
module dvt_sink import dvt_pkg::*; (
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  input  wire dvt_pkt_t i_pkt,
  input  wire logic     i_bta,
  output var int        o_vid,
  output var int        o_nul,
  output var int        o_syn,
  output var int        o_ack
);
  wire logic is_syn;
  assign is_syn = i_pkt.dt inside {DT_VSS, DT_VSE, DT_HSS, DT_HSE};
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_vid <= 0;
      o_nul <= 0;
      o_syn <= 0;
      o_ack <= 0;
    end
    else
    begin
      o_ack <= o_ack + int'(i_bta);
      if (i_pkt.valid && i_pkt.dt inside {DT_RGB565, DT_RGB666, DT_RGB666L,
          DT_RGB888}) o_vid <= o_vid + 1;
      if (i_pkt.valid && i_pkt.dt == DT_NULL) o_nul <= o_nul + 1;
      if (i_pkt.valid && is_syn) o_syn <= o_syn + 1;
    end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
// testbench: register and frame tests of the video timing block
`default_nettype none
`timescale 1ns/100ps
module testbench;
  import dvt_pkg::*;
  logic clk = 0, lbc = 0, rst_n = 0, we = 0, de = 1, vs = 0, cm = 0;
  logic [2:0] sel = '0;
  logic [31:0] wd = '0, rd;
  logic [1:0] lanes;
  logic lp, bta, cmo;
  logic [4:0] ph;
  dvt_pkt_t pkt;
  int n_errors = 0, comparisons = 0, nv, nn, ns, na;
  // 24 bpp, vc 2, 2 chunks of 4 pixels, 100-cycle lines, 5-line frame
  logic [31:0] cfg [6] = '{32'h1, 32'h216, 32'he00, 32'h00a01004,
    32'h01900402, 32'h00020411};
  initial forever #2.5 clk = ~clk;
  initial forever #6 lbc = ~lbc;
  dvt_top dvt_top_inst (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(1'b1),
    .I_LANE_BYTE_CLK(lbc), .I_DPI_DE(de), .I_DPI_VSYNC(vs),
    .I_DPI_HSYNC(1'b0), .I_DPI_SHUTDN(1'b0), .I_DPI_COLORM(cm),
    .I_CFG_WE(we), .I_CFG_SEL(sel), .I_CFG_WDATA(wd), .O_CFG_RDATA(rd),
    .O_PKT(pkt), .O_LANES(lanes), .O_LP_REQ(lp), .O_BTA_REQ(bta),
    .O_COLOR_MODE(cmo), .O_VPHASE(ph));
  dvt_sink dvt_sink_inst (.i_clk(lbc), .i_rst_n(rst_n), .i_pkt(pkt),
    .i_bta(bta), .o_vid(nv), .o_nul(nn), .o_syn(ns), .o_ack(na));
  // ******
  // access tasks
  // ******
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [2:0] s, logic [31:0] d);
    @(posedge clk) #1;
    we = 1;
    sel = s;
    wd = d;
    @(posedge clk) #1 we = 0;
    // link copy needs idle link cycles to settle
    repeat (8) @(posedge lbc);
  endtask
  task automatic rd_chk(string nm, logic [2:0] s, logic [31:0] e);
    @(posedge clk) #1 sel = s;
    repeat (2) @(posedge clk);
    #1 chk(nm, e, rd);
  endtask
  task automatic frame(logic [31:0] m, int ev, int en, int es, int eb);
    int v, n, s, a;
    wr(SEL_MODE, m);
    v = nv;
    n = nn;
    s = ns;
    a = na;
    @(posedge clk) #1 vs = 1;
    repeat (20) @(posedge clk);
    #1 vs = 0;
    for (int i = 0; i < 4000 && ph === 5'h01; i++) @(posedge lbc);
    for (int i = 0; i < 4000 && ph !== 5'h01; i++) @(posedge lbc);
    repeat (4) @(posedge lbc);
    chk("video packets", ev, nv - v);
    chk("null packets", en, nn - n);
    chk("sync packets", es, ns - s);
    chk("ack requests", eb, na - a);
    chk("end phase", 5'h01, ph);
    chk("end low power", 1, lp);
    $display("frame test done, mode %h", m);
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_errors++;
    close_out();
  end
  initial
  begin
    repeat (3) @(posedge lbc);
    #1 rst_n = 1;
    repeat (3) @(posedge clk);
    chk("idle low power", 1, lp);
    rd_chk("reset value", SEL_PHY, CFG_RST);
    for (int i = 0; i < 6; i++) wr(3'(i), cfg[i]);
    wr(SEL_STAT, 32'hffffffff);
    for (int i = 0; i < 6; i++) rd_chk("config", 3'(i), cfg[i]);
    rd_chk("unmapped", 3'h7, 32'h0);
    chk("lane count", 2'h1, lanes);
    chk("color mode", 1, cmo);
    $display("register test done");
    frame(32'he00, 4, 2, 10, 1);
    frame(32'h402, 2, 0, 5, 0);
    frame(32'h7fc, 2, 0, 5, 0);
    // packed 18 bpp: packet size of 4 pixels keeps the multiple of four
    wr(SEL_DPI, 32'h20e);
    frame(32'h402, 2, 0, 5, 0);
    close_out();
  end
endmodule
`default_nettype wire
